//--- afp_pkg.sv
// Shared constants and state type of the frame info field parser.
// Assumes one core clock; all users import the whole package.
package afp_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Buffer shape and channel limits
  localparam int AFP_FIFO_WIDTH = 1;
  localparam int AFP_FIFO_DEPTH = 32;
  localparam int AFP_MAX_CH = 5;

  ////////////////////////////////////////////////////////////////////////
  // Field widths in bits
  localparam logic [3:0] W_FLAG = 4'h1;
  localparam logic [3:0] W_ROOM = 4'h2;
  localparam logic [3:0] W_LEVEL = 4'h5;
  localparam logic [3:0] W_BYTE = 4'h8;
  localparam logic [3:0] W_TIME = 4'hE;
  localparam logic [3:0] W_ADDLEN = 4'h6;

  ////////////////////////////////////////////////////////////////////////
  // Field positions inside a 14-bit time code half
  localparam int TC_HOUR_LSB = 9;
  localparam int TC_MIN_LSB = 3;
  localparam int TC_SEC_LSB = 11;
  localparam int TC_FRAME_LSB = 6;

  ////////////////////////////////////////////////////////////////////////
  // Codes and reset values
  localparam logic [2:0] ACMOD_DUAL = 3'h0;
  localparam logic [1:0] ROOM_NONE = 2'h0;
  localparam logic [1:0] ROOM_RESERVED = 2'h3;
  localparam logic [4:0] DIAL_RESERVED = 5'h00;
  localparam logic [4:0] DIAL_FLOOR = 5'h1F;
  localparam logic [7:0] GAIN_RST = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE, ST_ROOM, ST_DIAL2, ST_COMP2E, ST_COMP2, ST_LANG2E, ST_LANG2,
    ST_PROD2E, ST_MIX2, ST_ROOM2, ST_COPY, ST_ORIG, ST_TC1E, ST_TC2E,
    ST_TC1, ST_TC2, ST_ADDE, ST_ADDL, ST_ADDB, ST_HDONE, ST_BSW, ST_DITH,
    ST_DRE, ST_DR, ST_DR2E, ST_DR2, ST_CPLSE, ST_CPLIN, ST_BDONE
  } afp_state_t;

endpackage

//--- afp_fifo_if.sv
// Valid/ready carrier between the parser and its bit buffer.
// Assumes both ends sit on the core clock.
`timescale 1ns/100ps
interface afp_fifo_if #(parameter int WIDTH = 1);
  logic [WIDTH-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [WIDTH-1:0] rdata;
  logic rvalid;
  logic rready;
  modport store (input wdata, wvalid, rready, output wready, rdata, rvalid);
  modport user (output wdata, wvalid, rready, input wready, rdata, rvalid);
endinterface

//--- afp_fifo.sv
// Flip-flop FIFO that buffers incoming stream bits ahead of the parser.
// Assumes DEPTH is a power of two so the pointers wrap by themselves.
`timescale 1ns/100ps
module afp_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  afp_fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic [AW:0] next_cnt;
  logic room;
  logic wr;
  logic rd;

  assign wr = q.wvalid && room;
  assign rd = q.rready && (cnt != '0);
  assign q.wready = room;
  assign q.rvalid = (cnt != '0);
  assign q.rdata = mem[rp];

  always_comb begin
    next_cnt = cnt;
    if (wr && !rd) begin
      next_cnt = cnt + 1'b1;
    end else if (rd && !wr) begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (wr) begin
      mem[wp] <= q.wdata;
    end
  end

  // Room is kept as a flop so the upstream ready has no logic path
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      room <= 1'b0;
    end else begin
      if (wr) wp <= wp + 1'b1;
      if (rd) rp <= rp + 1'b1;
      cnt <= next_cnt;
      room <= (next_cnt != FULL);
    end
  end

  fill_bound_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cnt == FULL) |-> !q.wready) else $error("fifo accepts while full");
endmodule

//--- afp_parser.sv
// Parser for the tail of the frame info header and the opening block fields.
// Assumes same-clock upstream logic feeding one bit per valid, MSB first.
`timescale 1ns/100ps
module afp_parser import afp_pkg::*; #(
  parameter int DEPTH = AFP_FIFO_DEPTH,
  parameter int NCH = AFP_MAX_CH
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_bit,
  input wire logic i_bit_valid,
  output logic o_bit_ready,
  input wire logic i_hdr_start,
  input wire logic i_blk_start,
  input wire logic [2:0] i_acmod,
  input wire logic i_prod_info_present,
  input wire logic [2:0] i_blk_num,
  input wire logic [2:0] i_nfchans,
  input wire logic i_done_ready,
  output logic o_done_valid,
  output logic o_busy,
  output logic [1:0] o_mixing_room_kind,
  output logic [4:0] o_second_dialogue_level,
  output logic o_second_compression_present,
  output logic [7:0] o_second_compression_gain,
  output logic o_second_language_present,
  output logic [7:0] o_second_language_id,
  output logic o_second_production_info_present,
  output logic [4:0] o_second_peak_mix_level,
  output logic [1:0] o_second_mixing_room_kind,
  output logic o_protected_flag,
  output logic o_original_flag,
  output logic o_coarse_time_present,
  output logic [4:0] o_time_hours,
  output logic [5:0] o_time_minutes,
  output logic [2:0] o_time_eight_sec,
  output logic o_fine_time_present,
  output logic [2:0] o_time_seconds,
  output logic [4:0] o_time_frames,
  output logic [5:0] o_time_fraction,
  output logic [NCH-1:0] o_block_split,
  output logic [NCH-1:0] o_dither_on,
  output logic [7:0] o_range_gain_word,
  output logic [7:0] o_second_range_gain_word,
  output logic o_coupling_new,
  output logic o_coupling_in_use,
  output logic o_coupling_params_follow
);

  ////////////////////////////////////////////////////////////////////////
  // Bit buffer
  afp_fifo_if #(.WIDTH(AFP_FIFO_WIDTH)) q ();

  afp_fifo #(.WIDTH(AFP_FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .q(q.store)
  );

  afp_state_t st;
  afp_state_t next_st;
  logic [3:0] cnt;
  logic [12:0] sh;
  logic [13:0] fv;
  logic take;
  logic done_f;
  logic [2:0] ch;
  logic [2:0] nch;
  logic ch_last;
  logic dual;
  logic [2:0] blk;
  logic [6:0] skip;

  assign q.wdata = i_bit;
  assign q.wvalid = i_bit_valid;
  assign o_bit_ready = q.wready;

  function automatic logic [3:0] flen(input afp_state_t s);
    case (s)
      ST_ROOM, ST_ROOM2: flen = W_ROOM;
      ST_DIAL2, ST_MIX2: flen = W_LEVEL;
      ST_COMP2, ST_LANG2, ST_ADDB, ST_DR, ST_DR2: flen = W_BYTE;
      ST_TC1, ST_TC2: flen = W_TIME;
      ST_ADDL: flen = W_ADDLEN;
      default: flen = W_FLAG;
    endcase
  endfunction

  // Bits are only drawn while a field is open, so waiting in a done
  // state stalls the buffer and back-pressures the source.
  assign take = q.rvalid && (st != ST_IDLE) && (st != ST_HDONE) && (st != ST_BDONE);
  assign q.rready = take;
  assign fv = {sh, q.rdata[0]};
  assign done_f = take && (cnt == flen(st) - 4'h1);
  assign ch_last = (ch == nch - 3'h1);

  ////////////////////////////////////////////////////////////////////////
  // Sequencing
  always_comb begin
    next_st = st;
    case (st)
      ST_IDLE: begin
        if (i_hdr_start) begin
          if (i_prod_info_present) next_st = ST_ROOM;
          else if (i_acmod == ACMOD_DUAL) next_st = ST_DIAL2;
          else next_st = ST_COPY;
        end else if (i_blk_start) begin
          next_st = ST_BSW;
        end
      end
      ST_ROOM: if (done_f) next_st = dual ? ST_DIAL2 : ST_COPY;
      ST_DIAL2: if (done_f) next_st = ST_COMP2E;
      ST_COMP2E: if (done_f) next_st = fv[0] ? ST_COMP2 : ST_LANG2E;
      ST_COMP2: if (done_f) next_st = ST_LANG2E;
      ST_LANG2E: if (done_f) next_st = fv[0] ? ST_LANG2 : ST_PROD2E;
      ST_LANG2: if (done_f) next_st = ST_PROD2E;
      ST_PROD2E: if (done_f) next_st = fv[0] ? ST_MIX2 : ST_COPY;
      ST_MIX2: if (done_f) next_st = ST_ROOM2;
      ST_ROOM2: if (done_f) next_st = ST_COPY;
      ST_COPY: if (done_f) next_st = ST_ORIG;
      ST_ORIG: if (done_f) next_st = ST_TC1E;
      ST_TC1E: if (done_f) next_st = ST_TC2E;
      ST_TC2E: if (done_f) next_st = o_coarse_time_present ? ST_TC1 :
        (fv[0] ? ST_TC2 : ST_ADDE);
      ST_TC1: if (done_f) next_st = o_fine_time_present ? ST_TC2 : ST_ADDE;
      ST_TC2: if (done_f) next_st = ST_ADDE;
      ST_ADDE: if (done_f) next_st = fv[0] ? ST_ADDL : ST_HDONE;
      ST_ADDL: if (done_f) next_st = ST_ADDB;
      ST_ADDB: if (done_f && skip == 7'h01) next_st = ST_HDONE;
      ST_BSW: if (done_f && ch_last) next_st = ST_DITH;
      ST_DITH: if (done_f && ch_last) next_st = ST_DRE;
      ST_DRE: if (done_f) next_st = fv[0] ? ST_DR : (dual ? ST_DR2E : ST_CPLSE);
      ST_DR: if (done_f) next_st = dual ? ST_DR2E : ST_CPLSE;
      ST_DR2E: if (done_f) next_st = fv[0] ? ST_DR2 : ST_CPLSE;
      ST_DR2: if (done_f) next_st = ST_CPLSE;
      ST_CPLSE: if (done_f) next_st = fv[0] ? ST_CPLIN : ST_BDONE;
      ST_CPLIN: if (done_f) next_st = ST_BDONE;
      ST_HDONE, ST_BDONE: if (i_done_ready) next_st = ST_IDLE;
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= ST_IDLE;
      o_done_valid <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      st <= next_st;
      o_done_valid <= (next_st == ST_HDONE) || (next_st == ST_BDONE);
      o_busy <= (next_st != ST_IDLE);
    end
  end

  // Frame context is latched at start so a changing mode input cannot
  // reshape a field sequence half way through.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dual <= 1'b0;
      blk <= 3'h0;
      nch <= 3'h1;
    end else if (st == ST_IDLE && (i_hdr_start || i_blk_start)) begin
      dual <= (i_acmod == ACMOD_DUAL);
      blk <= i_blk_num;
      nch <= (i_nfchans == 3'h0) ? 3'h1 : i_nfchans;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit collection, channel index and byte skip
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt <= 4'h0;
      sh <= '0;
    end else if (done_f) begin
      cnt <= 4'h0;
      sh <= '0;
    end else if (take) begin
      cnt <= cnt + 4'h1;
      sh <= fv[12:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ch <= 3'h0;
    end else if (done_f && (st == ST_BSW || st == ST_DITH)) begin
      ch <= ch_last ? 3'h0 : ch + 3'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      skip <= 7'h00;
    end else if (done_f && st == ST_ADDL) begin
      skip <= {1'b0, fv[5:0]} + 7'h01;
    end else if (done_f && st == ST_ADDB) begin
      skip <= skip - 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Header fields
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mixing_room_kind <= ROOM_NONE;
      o_second_dialogue_level <= DIAL_FLOOR;
      o_second_compression_present <= 1'b0;
      o_second_compression_gain <= GAIN_RST;
      o_second_language_present <= 1'b0;
      o_second_language_id <= 8'h00;
      o_second_production_info_present <= 1'b0;
      o_second_peak_mix_level <= 5'h00;
      o_second_mixing_room_kind <= ROOM_NONE;
      o_protected_flag <= 1'b0;
      o_original_flag <= 1'b0;
    end else if (done_f) begin
      case (st)
        // Reserved code keeps audio running and reads as not indicated
        ST_ROOM: o_mixing_room_kind <= (fv[1:0] == ROOM_RESERVED) ? ROOM_NONE : fv[1:0];
        ST_DIAL2: o_second_dialogue_level <=
          (fv[4:0] == DIAL_RESERVED) ? DIAL_FLOOR : fv[4:0];
        ST_COMP2E: o_second_compression_present <= fv[0];
        ST_COMP2: o_second_compression_gain <= fv[7:0];
        ST_LANG2E: o_second_language_present <= fv[0];
        ST_LANG2: o_second_language_id <= fv[7:0];
        ST_PROD2E: o_second_production_info_present <= fv[0];
        ST_MIX2: o_second_peak_mix_level <= fv[4:0];
        ST_ROOM2: begin
          o_second_mixing_room_kind <= (fv[1:0] == ROOM_RESERVED) ? ROOM_NONE : fv[1:0];
        end
        ST_COPY: o_protected_flag <= fv[0];
        ST_ORIG: o_original_flag <= fv[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_coarse_time_present <= 1'b0;
      o_fine_time_present <= 1'b0;
      o_time_hours <= 5'h00;
      o_time_minutes <= 6'h00;
      o_time_eight_sec <= 3'h0;
      o_time_seconds <= 3'h0;
      o_time_frames <= 5'h00;
      o_time_fraction <= 6'h00;
    end else if (done_f) begin
      case (st)
        ST_TC1E: o_coarse_time_present <= fv[0];
        ST_TC2E: o_fine_time_present <= fv[0];
        ST_TC1: begin
          o_time_hours <= fv[TC_HOUR_LSB+:5];
          o_time_minutes <= fv[TC_MIN_LSB+:6];
          o_time_eight_sec <= fv[2:0];
        end
        ST_TC2: begin
          o_time_seconds <= fv[TC_SEC_LSB+:3];
          o_time_frames <= fv[TC_FRAME_LSB+:5];
          o_time_fraction <= fv[5:0];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Block fields
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_block_split <= '0;
      o_dither_on <= '0;
    end else if (done_f && st == ST_BSW) begin
      o_block_split[ch] <= fv[0];
    end else if (done_f && st == ST_DITH) begin
      o_dither_on[ch] <= fv[0];
    end
  end

  // A missing word in block 0 clears, so stale gain never leaks into
  // a new frame.
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_range_gain_word <= GAIN_RST;
      o_second_range_gain_word <= GAIN_RST;
    end else if (done_f) begin
      case (st)
        ST_DRE: if (!fv[0] && blk == 3'h0) o_range_gain_word <= GAIN_RST;
        ST_DR: o_range_gain_word <= fv[7:0];
        ST_DR2E: if (!fv[0] && blk == 3'h0) o_second_range_gain_word <= GAIN_RST;
        ST_DR2: o_second_range_gain_word <= fv[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_coupling_new <= 1'b0;
      o_coupling_in_use <= 1'b0;
      o_coupling_params_follow <= 1'b0;
    end else if (done_f && st == ST_CPLSE) begin
      o_coupling_new <= fv[0];
      o_coupling_params_follow <= 1'b0;
    end else if (done_f && st == ST_CPLIN) begin
      o_coupling_in_use <= fv[0];
      o_coupling_params_follow <= fv[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  room_reserved_a: assert property (
    (done_f && st == ST_ROOM && fv[1:0] == ROOM_RESERVED) |=> o_mixing_room_kind == ROOM_NONE)
    else $error("reserved room code not mapped");
  dial_zero_a: assert property (
    (done_f && st == ST_DIAL2 && fv[4:0] == 5'h00) |=> o_second_dialogue_level == 5'h1F)
    else $error("dialogue code zero not floored");
  dual_only_a: assert property (
    (st == ST_DIAL2 || st == ST_DR2E) |-> dual)
    else $error("channel two field outside dual mode");
  lang_absent_a: assert property (
    (done_f && st == ST_LANG2E && !fv[0]) |=> !o_second_language_present ##1 st != ST_LANG2)
    else $error("absent language mishandled");
  skip_len_a: assert property (
    (done_f && st == ST_ADDL) |=> skip == {1'b0, $past(fv[5:0])} + 7'h01)
    else $error("skip byte count wrong");
  range_clear_a: assert property (
    (done_f && st == ST_DRE && !fv[0] && blk == 3'h0) |=> o_range_gain_word == 8'h00)
    else $error("range gain not cleared in block 0");
  range_hold_a: assert property (
    (done_f && st == ST_DRE && !fv[0] && blk != 3'h0) |=> $stable(o_range_gain_word))
    else $error("range gain not held");
  coarse_split_a: assert property (
    (done_f && st == ST_TC1) |=> o_time_hours == $past(fv[13:9]) &&
      o_time_eight_sec == $past(fv[2:0]))
    else $error("coarse time split wrong");
  cpl_keep_a: assert property (
    (done_f && st == ST_CPLSE && !fv[0]) |=> $stable(o_coupling_in_use) && st == ST_BDONE)
    else $error("coupling state not retained");
endmodule

//--- afp_src_model.sv
// Upstream bit source model: queues field bits and offers them one by one.
// Assumes the parser samples valid and ready on the rising core clock edge.
`timescale 1ns/100ps
module afp_src_model (
  input wire logic i_core_clk,
  input wire logic i_slow,
  input wire logic i_ready,
  output logic o_bit,
  output logic o_valid
);
  logic q[$];
  logic took;
  logic gap;

  initial begin
    o_bit = 1'h0;
    o_valid = 1'h0;
    took = 1'h0;
    gap = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Fields are queued most significant bit first
  task automatic push(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      q.push_back(v[i]);
    end
  endtask

  always @(posedge i_core_clk) begin
    took <= o_valid && i_ready;
  end

  // An offer stands until taken; an idle line toggles so stale bits never look valid
  always @(negedge i_core_clk) begin
    if (took) begin
      void'(q.pop_front());
      gap = i_slow;
    end
    if (o_valid && !took) begin
      o_valid = 1'h1;
    end else if (q.size() > 0 && !gap) begin
      o_valid = 1'h1;
      o_bit = q[0];
    end else begin
      o_valid = 1'h0;
      o_bit = ~o_bit;
      gap = 1'h0;
    end
  end
endmodule

//--- tb.sv
// Self-checking bench for the frame info field parser.
// Assumes the parser top with its internal bit buffer and the source model.
`timescale 1ns/100ps
module tb;
  import afp_pkg::*;
  typedef struct {logic [2:0] am; logic pi; logic [1:0] rm; logic [4:0] dl; logic c2e;
    logic [7:0] c2; logic l2e; logic [7:0] l2; logic p2e; logic [4:0] mx; logic [1:0] r2;
    logic cp; logic og; logic t1e; logic t2e; logic [13:0] t1; logic [13:0] t2; logic ae;
    logic [5:0] al; logic [1:0] x_rm; logic [4:0] x_dl;} afp_hrow_t;
  typedef struct {logic [2:0] am; logic [2:0] nc; logic [2:0] bn; logic [4:0] sp;
    logic [4:0] dt; logic dre; logic [7:0] dr; logic d2e; logic [7:0] d2; logic cse;
    logic cin; logic [7:0] x_dr; logic [7:0] x_d2; logic x_inu; logic x_fol;} afp_brow_t;

  logic i_core_clk, i_reset_n, i_bit, i_bit_valid, i_hdr_start, i_blk_start;
  logic [2:0] i_acmod, i_blk_num, i_nfchans;
  logic i_prod_info_present, i_done_ready, slow;
  logic o_bit_ready, o_done_valid, o_busy, o_second_compression_present;
  logic o_second_language_present, o_second_production_info_present;
  logic o_protected_flag, o_original_flag, o_coarse_time_present, o_fine_time_present;
  logic o_coupling_new, o_coupling_in_use, o_coupling_params_follow;
  logic [1:0] o_mixing_room_kind, o_second_mixing_room_kind;
  logic [4:0] o_second_dialogue_level, o_second_peak_mix_level, o_time_hours;
  logic [4:0] o_time_frames, o_block_split, o_dither_on;
  logic [7:0] o_second_compression_gain, o_second_language_id;
  logic [7:0] o_range_gain_word, o_second_range_gain_word;
  logic [5:0] o_time_minutes, o_time_fraction;
  logic [2:0] o_time_eight_sec, o_time_seconds;
  logic [13:0] tc1 = 14'h0000;
  logic [13:0] tc2 = 14'h0000;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  afp_hrow_t hrows[4] = '{
    '{3'h0, 1'h1, 2'h3, 5'h00, 1'h1, 8'hA5, 1'h1, 8'h3C, 1'h1, 5'h15, 2'h3, 1'h1, 1'h0, 1'h1,
      1'h1, {5'h17, 6'h3B, 3'h7}, {3'h7, 5'h1D, 6'h3F}, 1'h1, 6'h00, 2'h0, 5'h1F},
    '{3'h0, 1'h0, 2'h0, 5'h01, 1'h0, 8'h00, 1'h0, 8'h00, 1'h0, 5'h00, 2'h0, 1'h0, 1'h1, 1'h1,
      1'h0, {5'h00, 6'h01, 3'h0}, 14'h0000, 1'h1, 6'h3F, 2'h0, 5'h01},
    '{3'h2, 1'h1, 2'h1, 5'h00, 1'h0, 8'h00, 1'h0, 8'h00, 1'h0, 5'h00, 2'h0, 1'h1, 1'h1, 1'h0,
      1'h1, 14'h0000, {3'h3, 5'h0A, 6'h28}, 1'h0, 6'h00, 2'h1, 5'h01},
    '{3'h7, 1'h1, 2'h2, 5'h00, 1'h0, 8'h00, 1'h0, 8'h00, 1'h0, 5'h00, 2'h0, 1'h0, 1'h0, 1'h0,
      1'h0, 14'h0000, 14'h0000, 1'h0, 6'h00, 2'h2, 5'h01}};
  afp_brow_t brows[5] = '{
    '{3'h7, 3'h5, 3'h1, 5'h15, 5'h0A, 1'h1, 8'h7E, 1'h0, 8'h00, 1'h1, 1'h1,
      8'h7E, 8'h00, 1'h1, 1'h1},
    '{3'h7, 3'h5, 3'h2, 5'h0A, 5'h15, 1'h0, 8'h00, 1'h0, 8'h00, 1'h0, 1'h0,
      8'h7E, 8'h00, 1'h1, 1'h0},
    '{3'h0, 3'h2, 3'h0, 5'h01, 5'h02, 1'h0, 8'h00, 1'h1, 8'hC3, 1'h1, 1'h0,
      8'h00, 8'hC3, 1'h0, 1'h0},
    '{3'h0, 3'h2, 3'h3, 5'h02, 5'h01, 1'h1, 8'h11, 1'h0, 8'h00, 1'h0, 1'h0,
      8'h11, 8'hC3, 1'h0, 1'h0},
    '{3'h0, 3'h1, 3'h0, 5'h01, 5'h00, 1'h0, 8'h00, 1'h0, 8'h00, 1'h1, 1'h1,
      8'h00, 8'h00, 1'h1, 1'h1}};

  afp_parser dut (.*);
  afp_src_model src (.i_core_clk(i_core_clk), .i_slow(slow), .i_ready(o_bit_ready),
    .o_bit(i_bit), .o_valid(i_bit_valid));

  always #20 i_core_clk = ~i_core_clk;

  ////////////////////////////////////////////////////////////////////////
  // Shared checking and handshake tasks
  task automatic chk(input string nm, input logic [15:0] xp, input logic [15:0] got);
    n_compared++;
    if (got !== xp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, xp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Bits wait in the buffer first, so a long section must find it full and refusing
  task automatic run_section(input logic hdr);
    int k;
    int n;
    k = 0;
    n = src.q.size();
    cyc(80);
    if (n > 32) chk("bit_ready_full", 16'h0000, o_bit_ready);
    if (hdr) i_hdr_start = 1'h1;
    else i_blk_start = 1'h1;
    cyc(1);
    i_hdr_start = 1'h0;
    i_blk_start = 1'h0;
    while (o_done_valid !== 1'h1 && k < 2000) begin
      cyc(1);
      k++;
    end
    chk("done_valid", 16'h0001, o_done_valid);
    // A start while busy must be ignored
    i_hdr_start = 1'h1;
    cyc(1);
    i_hdr_start = 1'h0;
    i_done_ready = 1'h1;
    cyc(1);
    i_done_ready = 1'h0;
    cyc(2);
    chk("busy_after", 16'h0000, o_busy);
  endtask

  task automatic send_hdr(input afp_hrow_t r);
    if (r.pi) src.push(r.rm, 2);
    if (r.am == ACMOD_DUAL) begin
      src.push(r.dl, 5);
      src.push(r.c2e, 1);
      if (r.c2e) src.push(r.c2, 8);
      src.push(r.l2e, 1);
      if (r.l2e) src.push(r.l2, 8);
      src.push(r.p2e, 1);
      if (r.p2e) src.push({r.mx, r.r2}, 7);
    end
    src.push({r.cp, r.og, r.t1e, r.t2e}, 4);
    if (r.t1e) src.push(r.t1, 14);
    if (r.t2e) src.push(r.t2, 14);
    src.push(r.ae, 1);
    if (r.ae) src.push(r.al, 6);
    for (int i = 0; r.ae && i <= int'(r.al); i++) src.push(16'h00C3, 8);
    i_acmod = r.am;
    i_prod_info_present = r.pi;
    run_section(1'h1);
    if (r.pi) chk("room", r.x_rm, o_mixing_room_kind);
    if (r.am == ACMOD_DUAL) begin
      chk("dial2", r.x_dl, o_second_dialogue_level);
      chk("comp2_present", r.c2e, o_second_compression_present);
      if (r.c2e) chk("comp2", r.c2, o_second_compression_gain);
      chk("lang2_present", r.l2e, o_second_language_present);
      if (r.l2e) chk("lang2", r.l2, o_second_language_id);
      chk("prod2_present", r.p2e, o_second_production_info_present);
      if (r.p2e) chk("mix2", r.mx, o_second_peak_mix_level);
      if (r.p2e) chk("room2", (r.r2 == 2'h3) ? 2'h0 : r.r2, o_second_mixing_room_kind);
    end
    chk("protected", r.cp, o_protected_flag);
    chk("original", r.og, o_original_flag);
    chk("coarse_present", r.t1e, o_coarse_time_present);
    chk("fine_present", r.t2e, o_fine_time_present);
    if (r.t1e) tc1 = r.t1;
    if (r.t2e) tc2 = r.t2;
    chk("hours", tc1[13:9], o_time_hours);
    chk("minutes", tc1[8:3], o_time_minutes);
    chk("eight_sec", tc1[2:0], o_time_eight_sec);
    chk("seconds", tc2[13:11], o_time_seconds);
    chk("frames", tc2[10:6], o_time_frames);
    chk("fraction", tc2[5:0], o_time_fraction);
  endtask

  task automatic send_blk(input afp_brow_t r);
    logic [4:0] m;
    m = 5'h1F >> (3'h5 - r.nc);
    for (int c = 0; c < int'(r.nc); c++) src.push(r.sp[c], 1);
    for (int c = 0; c < int'(r.nc); c++) src.push(r.dt[c], 1);
    src.push(r.dre, 1);
    if (r.dre) src.push(r.dr, 8);
    if (r.am == ACMOD_DUAL) src.push(r.d2e, 1);
    if (r.am == ACMOD_DUAL && r.d2e) src.push(r.d2, 8);
    src.push(r.cse, 1);
    if (r.cse) src.push(r.cin, 1);
    i_acmod = r.am;
    i_nfchans = r.nc;
    i_blk_num = r.bn;
    run_section(1'h0);
    chk("split", r.sp & m, o_block_split & m);
    chk("dither", r.dt & m, o_dither_on & m);
    chk("range", r.x_dr, o_range_gain_word);
    chk("range2", r.x_d2, o_second_range_gain_word);
    chk("cpl_new", r.cse, o_coupling_new);
    chk("cpl_in_use", r.x_inu, o_coupling_in_use);
    chk("cpl_follow", r.x_fol, o_coupling_params_follow);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole run needs well under this many cycles
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    i_core_clk = 1'h0;
    i_reset_n = 1'h0;
    i_hdr_start = 1'h0;
    i_blk_start = 1'h0;
    i_acmod = 3'h0;
    i_blk_num = 3'h0;
    i_nfchans = 3'h1;
    i_prod_info_present = 1'h0;
    i_done_ready = 1'h0;
    slow = 1'h0;
    repeat (3) @(negedge i_core_clk);
    chk("ready_in_reset", 16'h0000, o_bit_ready);
    chk("dial2_reset", 16'h001F, o_second_dialogue_level);
    i_reset_n = 1'h1;
    cyc(2);
    chk("ready_after_reset", 16'h0001, o_bit_ready);
    foreach (hrows[i]) begin
      slow = i[0];
      send_hdr(hrows[i]);
      $display("Header case %0d finished", i);
    end
    foreach (brows[i]) begin
      slow = i[0];
      send_blk(brows[i]);
      $display("Block case %0d finished", i);
    end
    // Second reset in mid-run returns the held words to their reset values
    i_reset_n = 1'h0;
    cyc(1);
    chk("dial2_rerst", 16'h001F, o_second_dialogue_level);
    chk("hours_rerst", 16'h0000, o_time_hours);
    chk("ready_rerst", 16'h0000, o_bit_ready);
    i_reset_n = 1'h1;
    cyc(3);
    chk("ready_rerel", 16'h0001, o_bit_ready);
    $display("Reset case finished");
    wrap_up();
  end
endmodule
